// ### logic/tsi_defines.svh
// Constants of the touch sampling and interrupt control block
`ifndef TSI_DEFINES_SVH
`define TSI_DEFINES_SVH

// ====================================================================
// Timing
`define TSI_CLK_NS          8
`define TSI_TICK_NS         5000
`define TSI_SAMPLE_BASE_NS  320000
`define TSI_STEP_NS         35000000
`define TSI_CAL_NS          600000000

// ====================================================================
// Register indices, byte address is four times the index
`define TSI_IDX_STATUS      6'h02
`define TSI_IDX_INT_PEND    6'h03
`define TSI_IDX_RESULT      6'h10
`define TSI_IDX_CTRL        6'h20
`define TSI_IDX_INPUT_EN    6'h21
`define TSI_IDX_RPT_RATE    6'h22
`define TSI_IDX_MIN_PRESS   6'h23
`define TSI_IDX_AVG_SAMP    6'h24
`define TSI_IDX_CAL_REQ     6'h26
`define TSI_IDX_INT_EN      6'h27
`define TSI_IDX_RPT_EN      6'h28
`define TSI_IDX_CAL_VAL     6'h30
`define TSI_IDX_UNMAPPED    6'h25

// ====================================================================
// Reset values
`define TSI_RST_CTRL        8'h01
`define TSI_RST_INPUT_EN    8'h3F
`define TSI_RST_RPT_RATE    8'h04
`define TSI_RST_MIN_PRESS   8'h07
`define TSI_RST_AVG_SAMP    8'h39
`define TSI_RST_CAL_REQ     8'h00
`define TSI_RST_INT_EN      8'h3F
`define TSI_RST_RPT_EN      8'h3F

// ====================================================================
// Field positions
`define TSI_AVG_LSB         4
`define TSI_SAMP_LSB        2
`define TSI_CYC_LSB         0
`define TSI_CTRL_ACTIVE     0
`define TSI_CTRL_REL        1
`define TSI_STAT_LOWPWR     6
`define TSI_STAT_CAL        7

// ====================================================================
// Bus answers
`define TSI_RESP_OKAY       2'h0
`define TSI_RESP_SLVERR     2'h2

`endif

// ### logic/tsi_mem_if.sv
// Carrier between the sequencer and the result memory
`timescale 1ns/1ns
`default_nettype none
interface tsi_mem_if #(parameter int AW = 3, parameter int DW = 16);
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic          rd_en;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  modport host (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
  modport mem  (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface
`default_nettype wire

// ### logic/tsi_pkg.sv
// Types of the touch sampling and interrupt control block
package tsi_pkg;
  localparam int NCH = 6;
  typedef logic [2:0] tsi_ch_t;
  typedef enum logic [1:0] {TSI_IDLE, TSI_SAMPLE, TSI_LOWPWR} tsi_seq_e;
endpackage

// ### logic/tsi_result_mem.sv
// Averaged result memory, one word per touch input
`timescale 1ns/1ns
`default_nettype none
module tsi_result_mem #(
  parameter int DEPTH = 6,
  parameter int AW    = 3,
  parameter int DW    = 16
) (
  // Clock
  input wire logic aclk,
  // Access
  tsi_mem_if.mem   mem
);
  logic [DW-1:0] store_r [DEPTH];

  initial begin
    if (DEPTH < 1 || DEPTH > (1 << AW)) $error("tsi_result_mem: bad DEPTH");
  end

  always_ff @(posedge aclk) begin
    if (mem.wr_en) begin
      store_r[mem.wr_addr] <= mem.wr_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (mem.rd_en) begin
      mem.rd_data <= (32'(mem.rd_addr) < DEPTH) ? store_r[mem.rd_addr] : '0;
    end
  end
endmodule
`default_nettype wire

// ### logic/tsi_top.sv
// Touch sampling sequencer, calibration and interrupt control
// Operation
// - Averaging field selects 2^n samples per channel
// - Samples back to back, averaged, then stored
// - Sample-time field sets one sample's length
// - Cycle-time field sets cycle period 35-140ms
// - Sample at cycle start, then low power
// - Samples win; cycle stretched when too long
// - Sampling settings act only in Active state
// - Calibration request bit self-clears on success
// - Recalibrating input suppresses presses, base invalid
// - Press during recalibration restarts that attempt
// - Completion stores the 10-bit calibration value
// - Interrupt enable gates pin, status still set
// - No repeat: interrupt at touch and release
// - Repeat, short touch: touch and release interrupts
// - Press-and-hold repeats interrupt every repeat interval
// - Release control bit one suppresses release interrupt on repeat-enabled inputs
// - Repeat rate field, 35ms steps to 560ms
// - Touch longer than minimum press is hold
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "tsi_defines.svh"
module tsi_top #(
  parameter int TICK_CYCLES = `TSI_TICK_NS / `TSI_CLK_NS,
  parameter int SAMPLE_W    = 16
) (
  // Clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // AXI4-Lite write
  input  wire logic [7:0]          awaddr,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  // AXI4-Lite read
  input  wire logic [7:0]          araddr,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  // Touch pads and analog front end
  input  wire logic [5:0]          touch_raw,
  input  wire logic [SAMPLE_W-1:0] sample_value,
  output logic                     sample_strobe_r,
  output tsi_pkg::tsi_ch_t         sample_channel_r,
  output logic                     low_power_r,
  // Interrupt pin
  output logic                     alert_n_r
);
  import tsi_pkg::*;

  localparam int STEP_TICKS = `TSI_STEP_NS / `TSI_TICK_NS;
  localparam int SBASE      = `TSI_SAMPLE_BASE_NS / `TSI_TICK_NS;
  localparam int CAL_TICKS  = `TSI_CAL_NS / `TSI_TICK_NS;

  initial begin
    if (TICK_CYCLES < 1 || TICK_CYCLES > 1023) $error("tsi_top: bad TICK_CYCLES");
    if (SAMPLE_W < 10 || SAMPLE_W > 24) $error("tsi_top: bad SAMPLE_W");
  end

  // ==================================================================
  // Registers and base tick
  logic [7:0]  ctrl_r, inen_r, rrate_r, mpress_r, avgs_r, calreq_r, inten_r, rpten_r;
  logic [5:0]  pend_r, tsync1_r, tsync2_r, evt, cal_done;
  logic [9:0]  tick_cnt_r, cal_val_r [NCH], last_avg_r [NCH];
  logic        tick_r, wr_fire;
  logic [5:0]  wr_idx;
  logic [7:0]  wd;
  tsi_mem_if #(.AW(3), .DW(SAMPLE_W)) mif ();

  tsi_result_mem #(.DEPTH(NCH), .AW(3), .DW(SAMPLE_W)) u_mem (
    .aclk (aclk),
    .mem  (mif)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else begin
      tick_r     <= (tick_cnt_r == 10'(TICK_CYCLES - 1));
      tick_cnt_r <= (tick_cnt_r == 10'(TICK_CYCLES - 1)) ? '0 : tick_cnt_r + 10'h001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tsync1_r <= '0;
      tsync2_r <= '0;
    end else begin
      tsync1_r <= touch_raw;
      tsync2_r <= tsync1_r;
    end
  end

  // ==================================================================
  // Derived timings
  logic [2:0]  avg_code;
  logic [8:0]  avg_n;
  logic [9:0]  samp_ticks;
  logic [19:0] cyc_ticks;
  logic [16:0] rpt_ticks, mp_ticks;
  logic        active, rel_ctrl;
  assign avg_code   = avgs_r[`TSI_AVG_LSB +: 3];
  assign avg_n      = 9'h001 << avg_code;
  assign samp_ticks = 10'(SBASE) << avgs_r[`TSI_SAMP_LSB +: 2];
  assign cyc_ticks  = 20'(({18'h0, avgs_r[`TSI_CYC_LSB +: 2]} + 20'h1) * STEP_TICKS);
  assign rpt_ticks  = 17'(({13'h0, rrate_r[3:0]} + 17'h1) * STEP_TICKS);
  assign mp_ticks   = 17'(({13'h0, mpress_r[3:0]} + 17'h1) * STEP_TICKS);
  assign active     = ctrl_r[`TSI_CTRL_ACTIVE];
  assign rel_ctrl   = ctrl_r[`TSI_CTRL_REL];

  function automatic logic [3:0] next_en(input logic [5:0] en, input logic [3:0] from);
    logic [3:0] r;
    r = 4'(NCH);
    for (int k = NCH - 1; k >= 0; k--) begin
      if (en[k] && 4'(k) >= from) r = 4'(k);
    end
    return r;
  endfunction

  // ==================================================================
  // Sensor cycle sequencer
  tsi_seq_e    state_r;
  tsi_ch_t     ch_r;
  logic [9:0]  samp_cnt_r;
  logic [8:0]  n_r;
  logic [19:0] cyc_cnt_r;
  logic [SAMPLE_W+6:0] acc_r, acc_nxt;
  logic        samp_end, ch_end, cyc_over;
  logic [3:0]  first_ch, after_ch;
  assign samp_end = active && (state_r == TSI_SAMPLE) && tick_r
                 && (samp_cnt_r >= samp_ticks - 10'h1);
  assign cyc_over = (cyc_cnt_r >= cyc_ticks)
                 || (tick_r && cyc_cnt_r >= cyc_ticks - 20'h1);
  assign acc_nxt  = acc_r + (SAMPLE_W+7)'(sample_value);
  assign ch_end   = samp_end && (n_r + 9'h1 >= avg_n);
  assign first_ch = next_en(inen_r[5:0], 4'h0);
  assign after_ch = next_en(inen_r[5:0], {1'b0, ch_r} + 4'h1);
  assign mif.wr_en   = ch_end;
  assign mif.wr_addr = ch_r;
  assign mif.wr_data = SAMPLE_W'(acc_nxt >> avg_code);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r    <= TSI_IDLE;
      ch_r       <= '0;
      samp_cnt_r <= '0;
      n_r        <= '0;
      acc_r      <= '0;
      cyc_cnt_r  <= '0;
    end else begin
      if (tick_r && cyc_cnt_r != 20'hFFFFF) cyc_cnt_r <= cyc_cnt_r + 20'h1;
      case (state_r)
        TSI_IDLE: begin
          if (active) begin
            cyc_cnt_r  <= '0;
            samp_cnt_r <= '0;
            n_r        <= '0;
            acc_r      <= '0;
            ch_r       <= 3'(first_ch);
            state_r    <= (first_ch == 4'(NCH)) ? TSI_LOWPWR : TSI_SAMPLE;
          end
        end
        TSI_SAMPLE: begin
          if (!active) begin
            state_r <= TSI_IDLE;
          end else if (samp_end) begin
            samp_cnt_r <= '0;
            if (ch_end) begin
              n_r   <= '0;
              acc_r <= '0;
              if (after_ch == 4'(NCH)) begin
                state_r <= cyc_over ? TSI_IDLE : TSI_LOWPWR;
              end else begin
                ch_r <= 3'(after_ch);
              end
            end else begin
              n_r   <= n_r + 9'h1;
              acc_r <= acc_nxt;
            end
          end else if (tick_r) begin
            samp_cnt_r <= samp_cnt_r + 10'h1;
          end
        end
        TSI_LOWPWR: begin
          if (!active || cyc_over) state_r <= TSI_IDLE;
        end
        default: state_r <= TSI_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_strobe_r  <= 1'b0;
      sample_channel_r <= '0;
      low_power_r      <= 1'b0;
    end else begin
      sample_strobe_r  <= samp_end;
      sample_channel_r <= ch_r;
      low_power_r      <= (state_r == TSI_LOWPWR);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int k = 0; k < NCH; k++) last_avg_r[k] <= '0;
    end else if (ch_end) begin
      last_avg_r[ch_r] <= mif.wr_data[9:0];
    end
  end

  // ==================================================================
  // Per-input touch, repeat and calibration
  logic [5:0] touch_ok;
  assign touch_ok = tsync2_r & ~calreq_r[5:0];

  for (genvar i = 0; i < NCH; i++) begin : g_in
    logic        prev_r, press, release_ev, is_hold, rep_hit;
    logic [16:0] hold_cnt_r, rep_cnt_r, cal_cnt_r;
    assign press      = touch_ok[i] & ~prev_r;
    assign release_ev = ~touch_ok[i] & prev_r;
    assign is_hold    = rpten_r[i] && (hold_cnt_r > mp_ticks);
    assign rep_hit    = touch_ok[i] && is_hold && tick_r && (rep_cnt_r >= rpt_ticks - 17'h1);
    assign evt[i]     = press | rep_hit
                      | (release_ev & (~rpten_r[i] | ~rel_ctrl));
    assign cal_done[i] = calreq_r[i] && !tsync2_r[i] && tick_r
                      && (cal_cnt_r == 17'(CAL_TICKS - 1));

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        prev_r     <= 1'b0;
        hold_cnt_r <= '0;
        rep_cnt_r  <= '0;
      end else begin
        prev_r <= touch_ok[i];
        if (press) begin
          hold_cnt_r <= '0;
          rep_cnt_r  <= '0;
        end else if (touch_ok[i] && tick_r) begin
          if (hold_cnt_r != 17'h1FFFF) hold_cnt_r <= hold_cnt_r + 17'h1;
          rep_cnt_r <= (rep_cnt_r >= rpt_ticks - 17'h1) ? '0 : rep_cnt_r + 17'h1;
        end
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cal_cnt_r    <= '0;
        cal_val_r[i] <= '0;
      end else begin
        if (!calreq_r[i] || tsync2_r[i]) cal_cnt_r <= '0;
        else if (tick_r) cal_cnt_r <= cal_cnt_r + 17'h1;
        if (cal_done[i]) cal_val_r[i] <= last_avg_r[i];
      end
    end
  end

  // ==================================================================
  // AXI4-Lite slave
  logic       aw_hold_r, w_hold_r, rd_stage_r;
  logic [5:0] aw_idx_r, ar_idx_r;
  logic [7:0] wdat_r;
  logic       wstrb0_r;
  assign wr_fire = aw_hold_r && w_hold_r && !bvalid;
  assign wr_idx  = aw_idx_r;
  assign wd      = wstrb0_r ? wdat_r : 8'h00;
  assign mif.rd_en   = arvalid && arready;
  assign mif.rd_addr = 3'(araddr[7:2] - `TSI_IDX_RESULT);

  function automatic logic mapped(input logic [5:0] x);
    return (x == `TSI_IDX_STATUS) || (x == `TSI_IDX_INT_PEND)
        || (x >= `TSI_IDX_RESULT && x < `TSI_IDX_RESULT + 6'(NCH))
        || (x >= `TSI_IDX_CTRL && x <= `TSI_IDX_RPT_EN && x != `TSI_IDX_UNMAPPED)
        || (x >= `TSI_IDX_CAL_VAL && x < `TSI_IDX_CAL_VAL + 6'(NCH));
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      aw_idx_r  <= '0;
      wdat_r    <= '0;
      wstrb0_r  <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= `TSI_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_hold_r <= 1'b1;
        aw_idx_r  <= awaddr[7:2];
        awready   <= 1'b0;
      end
      if (wvalid && wready) begin
        w_hold_r <= 1'b1;
        wdat_r   <= wdata[7:0];
        wstrb0_r <= wstrb[0];
        wready   <= 1'b0;
      end
      if (wr_fire) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= mapped(wr_idx) ? `TSI_RESP_OKAY : `TSI_RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // Writable registers, write-one-to-clear pending bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r   <= `TSI_RST_CTRL;
      inen_r   <= `TSI_RST_INPUT_EN;
      rrate_r  <= `TSI_RST_RPT_RATE;
      mpress_r <= `TSI_RST_MIN_PRESS;
      avgs_r   <= `TSI_RST_AVG_SAMP;
      inten_r  <= `TSI_RST_INT_EN;
      rpten_r  <= `TSI_RST_RPT_EN;
      calreq_r <= `TSI_RST_CAL_REQ;
      pend_r   <= '0;
      alert_n_r <= 1'b1;
    end else begin
      if (wr_fire && wstrb0_r) begin
        case (wr_idx)
          `TSI_IDX_CTRL:      ctrl_r   <= wd & 8'h03;
          `TSI_IDX_INPUT_EN:  inen_r   <= wd & 8'h3F;
          `TSI_IDX_RPT_RATE:  rrate_r  <= wd & 8'h0F;
          `TSI_IDX_MIN_PRESS: mpress_r <= wd & 8'h0F;
          `TSI_IDX_AVG_SAMP:  avgs_r   <= wd & 8'h7F;
          `TSI_IDX_INT_EN:    inten_r  <= wd & 8'h3F;
          `TSI_IDX_RPT_EN:    rpten_r  <= wd & 8'h3F;
          default: ;
        endcase
      end
      if (wr_fire && wstrb0_r && wr_idx == `TSI_IDX_CAL_REQ) begin
        calreq_r <= {2'b00, wd[5:0]};
      end else begin
        calreq_r <= {2'b00, calreq_r[5:0] & ~cal_done};
      end
      pend_r <= (pend_r & ~((wr_fire && wstrb0_r && wr_idx == `TSI_IDX_INT_PEND) ?
                 wd[5:0] : 6'h00)) | (evt & inten_r[5:0]);
      alert_n_r <= ~|pend_r;
    end
  end

  // Read path, data one edge after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready    <= 1'b1;
      rd_stage_r <= 1'b0;
      ar_idx_r   <= '0;
      rvalid     <= 1'b0;
      rdata      <= '0;
      rresp      <= `TSI_RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready    <= 1'b0;
        rd_stage_r <= 1'b1;
        ar_idx_r   <= araddr[7:2];
      end
      if (rd_stage_r) begin
        rd_stage_r <= 1'b0;
        rvalid     <= 1'b1;
        rresp      <= mapped(ar_idx_r) ? `TSI_RESP_OKAY : `TSI_RESP_SLVERR;
        rdata      <= '0;
        if (ar_idx_r >= `TSI_IDX_RESULT && ar_idx_r < `TSI_IDX_RESULT + 6'(NCH)) begin
          rdata <= 32'(mif.rd_data);
        end else if (ar_idx_r >= `TSI_IDX_CAL_VAL && ar_idx_r < `TSI_IDX_CAL_VAL + 6'(NCH)) begin
          rdata <= 32'(cal_val_r[3'(ar_idx_r - `TSI_IDX_CAL_VAL)]);
        end else begin
          case (ar_idx_r)
            `TSI_IDX_STATUS:    rdata <= {24'h0, |calreq_r[5:0], low_power_r, tsync2_r & ~calreq_r[5:0]};
            `TSI_IDX_INT_PEND:  rdata <= {26'h0, pend_r};
            `TSI_IDX_CTRL:      rdata <= {24'h0, ctrl_r};
            `TSI_IDX_INPUT_EN:  rdata <= {24'h0, inen_r};
            `TSI_IDX_RPT_RATE:  rdata <= {24'h0, rrate_r};
            `TSI_IDX_MIN_PRESS: rdata <= {24'h0, mpress_r};
            `TSI_IDX_AVG_SAMP:  rdata <= {24'h0, avgs_r};
            `TSI_IDX_CAL_REQ:   rdata <= {24'h0, calreq_r};
            `TSI_IDX_INT_EN:    rdata <= {24'h0, inten_r};
            `TSI_IDX_RPT_EN:    rdata <= {24'h0, rpten_r};
            default:            rdata <= '0;
          endcase
        end
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/tb_tsi_top.sv
// Testbench of the touch sampling and interrupt control block
`timescale 1ns/1ns
`default_nettype none
module tb_tsi_top;
  import tsi_pkg::*;
  localparam int TK = 2;
  logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic [5:0] touch_raw = 6'h00;
  logic awready, wready, bvalid, arready, rvalid, sample_strobe_r, low_power_r, alert_n_r;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] sample_value;
  tsi_ch_t sample_channel_r;
  int mismatches = 0, cmp_count = 0, cyc = 0, nstb = 0, lp_seen = 0, i;
  tsi_ch_t chq[$];
  int tq[$];
  logic [7:0] ra[4] = '{8'h90, 8'h98, 8'h9C, 8'hA0};
  logic [31:0] rv[4] = '{32'h39, 32'h00, 32'h3F, 32'h3F};

  tsi_top #(.TICK_CYCLES(TK)) uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .touch_raw, .sample_value, .sample_strobe_r, .sample_channel_r,
    .low_power_r, .alert_n_r);
  tsi_afe_model afe (.aclk, .aresetn, .sample_strobe_r, .sample_value);

  // ==================================================================
  // Clock, timeout and sample monitor
  initial begin
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (sample_strobe_r === 1'h1) begin
      chq.push_back(sample_channel_r);
      tq.push_back(cyc);
      nstb++;
    end
    if (low_power_r === 1'h1) lp_seen = 1;
    if (cyc == 60000) begin
      mismatches++;
      summarize();
    end
  end

  // ==================================================================
  // Compare, bus tasks and closing report
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid === 1'h1) begin
        bready <= 1'h0;
        chk({30'h0, bresp}, {30'h0, er});
        break;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF,
                    input logic [1:0] er = 2'h0);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid === 1'h1) begin
        rready <= 1'h0;
        chk(rdata & m, e);
        chk({30'h0, rresp}, {30'h0, er});
        break;
      end
    end
  endtask
  task automatic alert_wait(input logic v);
    for (int k = 0; k < 30 && alert_n_r !== v; k++) @(posedge aclk);
    chk({31'h0, alert_n_r}, {31'h0, v});
  endtask
  task automatic restart(input logic [31:0] cfg, input logic [31:0] en);
    wr(8'h80, 32'h0, 2'h0);
    repeat (4) @(posedge aclk);
    nstb = 0;
    chq.delete();
    tq.delete();
    wr(8'h90, cfg, 2'h0);
    wr(8'h84, en, 2'h0);
    lp_seen = 0;
    wr(8'h80, 32'h1, 2'h0);
  endtask
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ==================================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    for (i = 0; i < 4; i++) rd(ra[i], rv[i]);
    rd(8'h94, 32'h0, 32'hFFFFFFFF, 2'h2);
    wr(8'h94, 32'hFF, 2'h2);
    wstrb <= 4'h0;
    wr(8'h9C, 32'h0, 2'h0);
    wstrb <= 4'hF;
    rd(8'h9C, 32'h3F);
    wr(8'h98, 32'h1, 2'h0);
    rd(8'h98, 32'h1);
    rd(8'h08, 32'h80, 32'h80);
    touch_raw <= 6'h01;
    repeat (20) @(posedge aclk);
    chk({31'h0, alert_n_r}, 32'h1);
    touch_raw <= 6'h00;
    repeat (10) @(posedge aclk);
    wr(8'h98, 32'h0, 2'h0);
    rd(8'h98, 32'h0);
    wr(8'hA0, 32'h0, 2'h0);
    touch_raw <= 6'h01;
    alert_wait(1'h0);
    rd(8'h0C, 32'h1, 32'h3F);
    wr(8'h0C, 32'h1, 2'h0);
    alert_wait(1'h1);
    repeat (100) @(posedge aclk);
    chk({31'h0, alert_n_r}, 32'h1);
    touch_raw <= 6'h00;
    alert_wait(1'h0);
    wr(8'h0C, 32'h1, 2'h0);
    alert_wait(1'h1);
    wr(8'hA0, 32'h3F, 2'h0);
    wr(8'h80, 32'h3, 2'h0);
    touch_raw <= 6'h01;
    alert_wait(1'h0);
    wr(8'h0C, 32'h1, 2'h0);
    alert_wait(1'h1);
    touch_raw <= 6'h00;
    repeat (30) @(posedge aclk);
    chk({31'h0, alert_n_r}, 32'h1);
    wr(8'h80, 32'h1, 2'h0);
    touch_raw <= 6'h01;
    alert_wait(1'h0);
    wr(8'h0C, 32'h1, 2'h0);
    alert_wait(1'h1);
    touch_raw <= 6'h00;
    alert_wait(1'h0);
    wr(8'h0C, 32'h1, 2'h0);
    alert_wait(1'h1);
    wr(8'h9C, 32'h3D, 2'h0);
    touch_raw <= 6'h02;
    repeat (20) @(posedge aclk);
    chk({31'h0, alert_n_r}, 32'h1);
    rd(8'h08, 32'h02, 32'h3F);
    touch_raw <= 6'h00;
    repeat (20) @(posedge aclk);
    wr(8'h9C, 32'h3F, 2'h0);
    wr(8'h80, 32'h0, 2'h0);
    @(posedge aclk);
    nstb = 0;
    repeat (200) @(posedge aclk);
    chk(nstb, 0);
    restart(32'h10, 32'h05);
    for (i = 0; i < 3000 && lp_seen == 0; i++) @(posedge aclk);
    chk(chq.size(), 4);
    chk(lp_seen, 1);
    for (i = 0; i < 4; i++) chk(chq[i], (i < 2) ? 0 : 2);
    chk(tq[1] - tq[0], 64 * TK);
    for (i = 0; i < 15000 && nstb < 5; i++) @(posedge aclk);
    chk(tq[4] - tq[0], 7000 * TK);
    rd(8'h40, 32'h20);
    rd(8'h48, 32'h20);
    restart(32'h4C, 32'h01);
    for (i = 0; i < 20000 && nstb < 17; i++) @(posedge aclk);
    chk(lp_seen, 0);
    chk(chq.size(), 17);
    chk(tq[16] - tq[15], 512 * TK);
    chk(tq[1] - tq[0], 512 * TK);
    summarize();
  end
endmodule
`default_nettype wire

// ### tb/tsi_afe_model.sv
// Front end model that feeds sample values to the sequencer
`timescale 1ns/1ns
`default_nettype none
module tsi_afe_model (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Sample handshake
  input  wire logic        sample_strobe_r,
  output logic [15:0]      sample_value
);
  // ==================================================================
  // Value toggles 10h/30h on each capture, pairs average to 20h
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_value <= 16'h0010;
    end else if (sample_strobe_r) begin
      sample_value <= sample_value ^ 16'h0020;
    end
  end
endmodule
`default_nettype wire

// ### tb/tsi_props.sv
// Checker of the bus handshake and sequencer outputs
`timescale 1ns/1ns
`default_nettype none
module tsi_props #(
  parameter int TICK_CYCLES = 625
) (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [7:0]  araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  // Sequencer
  input wire logic        sample_strobe_r,
  input wire logic        low_power_r
);
  // ==================================================================
  // Properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd_ans;
    !arready ##1 rvalid;
  endsequence
  a_wr_answer: assert property (s_wr_take |-> ##2 bvalid)
    else $error("write answer late");
  a_wr_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  a_wr_block: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while answer pending");
  a_rd_answer: assert property (arvalid && arready |=> s_rd_ans)
    else $error("read answer late");
  a_rd_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped");
  a_rd_unmapped: assert property (arvalid && arready && araddr[7:2] == 6'h25
    |-> ##2 (rresp == 2'h2 && rdata == 32'h0))
    else $error("unmapped read answered wrongly");
  a_strobe_pulse: assert property (sample_strobe_r |=> !sample_strobe_r)
    else $error("strobe longer than one cycle");
  a_lowpwr_quiet: assert property (low_power_r |-> !sample_strobe_r)
    else $error("sample in low power");
endmodule
bind tsi_top tsi_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (.aclk, .aresetn, .awvalid,
  .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
  .rdata, .rresp, .rvalid, .rready, .sample_strobe_r, .low_power_r);
`default_nettype wire
